// ---- src/pir_config_reads.sv ----
// Purpose: Answers package config read services with identity, error, unit and SKU words
// Assumes: Host waits for rsp_valid before issuing the next request
// Notes: Request table reads go through a one-cycle external read port
//
// Behaviour
// - Service 39 returns table entries for enabled cores after three strikes, or core id with valid.
// - Signature word packs stepping, model, family, type, extended model and family.
// - Platform read returns the three platform flag bits in bits 2:0.
// - Power control unit identity is a fixed constant for all variants.
// - Thread count read reports supported threads regardless of disabled cores.
// - Microcode read returns the 32-bit combined microcode and firmware revision.
// - Machine check word sets bits 29, 30, 31 on errors; log in 28:0.
// - Power unit field, bits 3:0, defaults to 0011.
// - Energy unit field, bits 12:8, defaults to 10000.
// - Time unit field, bits 19:16, defaults to 1010.
// - A unit is one second, joule or watt over two to the field.
// - The 64-bit SKU word is read as two separate 32-bit halves.
// - SKU power values are scaled by the power unit field.
// - SKU data is loaded at boot from fixed variant defaults.
// - SKU bits 14:0 hold design power, bits 46:32 maximum power.
// - SKU bits 30:16 hold the minimum package power for both limits.
// - SKU bits 54:48 hold the maximum time window.
`timescale 1ns/100ps

module pir_config_reads (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [7:0] req_index,
  input wire logic [15:0] req_param,
  output logic rsp_valid,
  output logic rsp_ok,
  output logic [31:0] rsp_data,
  input wire pir_pkg::pir_sig_word_type signature,
  input wire logic [2:0] platform_flags,
  input wire logic [7:0] max_thread_count,
  input wire logic [31:0] microcode_rev,
  input wire logic machine_check_error_flag,
  input wire logic internal_error_flag,
  input wire logic catastrophic_error_signal_n,
  input wire logic [28:0] error_source_log,
  input wire pir_pkg::pir_sku_word_type sku_default,
  input wire logic [15:0] core_enable_mask,
  input wire logic timeout_strike,
  input wire logic [3:0] timeout_core_id,
  input wire logic timeout_core_valid,
  output logic table_rd_en,
  output logic [3:0] table_rd_slice,
  output logic [3:0] table_rd_entry,
  output logic [1:0] table_rd_bank,
  input wire logic [31:0] table_rd_data
);

  // ==========================================================
  // State
  pir_pkg::pir_state_type s_reg;
  pir_pkg::pir_state_type s_next;
  pir_pkg::pir_tbl_param_type tbl_param;
  logic req_idle;
  logic tbl_allowed;

  assign tbl_param = req_param;
  assign req_idle = req_valid && (s_reg.phase == pir_pkg::PH_IDLE);
  // Entries only exist for a core that is enabled and only once the timeout has struck thrice
  assign tbl_allowed = (s_reg.strikes == pir_pkg::STRIKE_LIMIT)
    && core_enable_mask[tbl_param.slice];

  function automatic logic id_read(input logic [15:0] code);
    id_read = req_idle && (req_index == pir_pkg::SVC_PKG_ID) && (req_param == code);
  endfunction

  function automatic logic svc_read(input logic [7:0] index);
    svc_read = req_idle && (req_index == index);
  endfunction

  // ==========================================================
  // Next state
  always_comb
  begin
    pir_pkg::pir_sig_word_type sig;
    pir_pkg::pir_mc_word_type mc;
    pir_pkg::pir_core_word_type core;
    sig = signature;
    sig.rsvd_hi = 4'h0;
    sig.rsvd_mid = 2'h0;
    mc.cat_err = s_reg.cat_err;
    mc.int_err = s_reg.int_err;
    mc.mc_err = s_reg.mc_err;
    mc.source_log = error_source_log;
    core.rsvd = 27'h0000000;
    core.valid = timeout_core_valid;
    core.core_id = timeout_core_id;
    s_next = s_reg;
    s_next.rsp_valid = 1'b0;
    s_next.tbl_en = 1'b0;

    // Strike count saturates so a later strike cannot wrap it back to zero
    if (timeout_strike && (s_reg.strikes != pir_pkg::STRIKE_LIMIT))
    begin
      s_next.strikes = s_reg.strikes + 2'h1;
    end

    // Error bits are sticky until reset; nothing else clears them
    if (machine_check_error_flag)
    begin
      s_next.mc_err = 1'b1;
    end
    if (internal_error_flag)
    begin
      s_next.int_err = 1'b1;
    end
    if (!catastrophic_error_signal_n)
    begin
      s_next.cat_err = 1'b1;
    end

    // SKU limits are taken once, on the first cycle out of reset
    if (!s_reg.sku_loaded)
    begin
      s_next.sku_loaded = 1'b1;
      s_next.sku = '0;
      s_next.sku.design_thermal_power = sku_default.design_thermal_power;
      s_next.sku.max_power = sku_default.max_power;
      s_next.sku.min_power = sku_default.min_power;
      s_next.sku.max_window = sku_default.max_window;
    end

    unique case (s_reg.phase)
      pir_pkg::PH_IDLE:
      begin
        if (req_valid)
        begin
          s_next.rsp_valid = 1'b1;
          s_next.rsp_ok = 1'b1;
          s_next.rsp_data = 32'h0000_0000;
          if (req_index == pir_pkg::SVC_PKG_ID)
          begin
            unique case (req_param)
              pir_pkg::ID_SIGNATURE: s_next.rsp_data = sig;
              pir_pkg::ID_PLATFORM: s_next.rsp_data = {29'h00000000, platform_flags};
              pir_pkg::ID_DEVICE: s_next.rsp_data = pir_pkg::PCU_DEVICE_ID;
              pir_pkg::ID_THREADS: s_next.rsp_data = {24'h000000, max_thread_count};
              pir_pkg::ID_MICROCODE: s_next.rsp_data = microcode_rev;
              pir_pkg::ID_MACHINE_CHECK: s_next.rsp_data = mc;
              default: s_next.rsp_ok = 1'b0;
            endcase
          end
          else if (req_index == pir_pkg::SVC_SKU_UNIT)
          begin
            // Host scales time, energy and power as one unit over two to each field
            s_next.rsp_data = pir_pkg::UNIT_WORD;
          end
          else if (req_index == pir_pkg::SVC_SKU_LO)
          begin
            s_next.rsp_data = s_reg.sku[31:0];
          end
          else if (req_index == pir_pkg::SVC_SKU_HI)
          begin
            s_next.rsp_data = s_reg.sku[63:32];
          end
          else if (req_index == pir_pkg::SVC_REQ_TABLE)
          begin
            if (tbl_param.read_mode)
            begin
              s_next.rsp_data = core;
            end
            else if (tbl_allowed)
            begin
              // The answer waits for the external table port
              s_next.rsp_valid = 1'b0;
              s_next.tbl_en = 1'b1;
              s_next.tbl_slice = tbl_param.slice;
              s_next.tbl_entry = tbl_param.entry;
              s_next.tbl_bank = tbl_param.bank;
              s_next.phase = pir_pkg::PH_ADDR;
            end
            else
            begin
              s_next.rsp_ok = 1'b0;
            end
          end
          else
          begin
            s_next.rsp_ok = 1'b0;
          end
        end
      end
      pir_pkg::PH_ADDR:
      begin
        s_next.phase = pir_pkg::PH_DATA;
      end
      pir_pkg::PH_DATA:
      begin
        s_next.rsp_valid = 1'b1;
        s_next.rsp_ok = 1'b1;
        s_next.rsp_data = table_rd_data;
        s_next.phase = pir_pkg::PH_IDLE;
      end
      default:
      begin
        s_next.phase = pir_pkg::PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= pir_pkg::STATE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rsp_valid = s_reg.rsp_valid;
  assign rsp_ok = s_reg.rsp_ok;
  assign rsp_data = s_reg.rsp_data;
  assign table_rd_en = s_reg.tbl_en;
  assign table_rd_slice = s_reg.tbl_slice;
  assign table_rd_entry = s_reg.tbl_entry;
  assign table_rd_bank = s_reg.tbl_bank;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_table_latency:
  assert property (svc_read(pir_pkg::SVC_REQ_TABLE) && !tbl_param.read_mode && tbl_allowed
    |=> table_rd_en && !rsp_valid ##1 !table_rd_en && !rsp_valid ##1 rsp_valid && rsp_ok)
  else $error("table read answer timing wrong");

  a_table_refused:
  assert property (svc_read(pir_pkg::SVC_REQ_TABLE) && !tbl_param.read_mode && !tbl_allowed
    |=> rsp_valid && !rsp_ok && !table_rd_en)
  else $error("table read not refused");

  a_signature_fields:
  assert property (id_read(pir_pkg::ID_SIGNATURE) |=> rsp_data[31:28] == 4'h0
    && rsp_data[15:14] == 2'h0 && rsp_data[27:16] == $past(signature[27:16]))
  else $error("signature word wrong");

  a_platform_flags:
  assert property (id_read(pir_pkg::ID_PLATFORM)
    |=> rsp_valid && rsp_data == {29'h00000000, $past(platform_flags)})
  else $error("platform flags wrong");

  a_device_identity:
  assert property (id_read(pir_pkg::ID_DEVICE) |=> rsp_data == pir_pkg::PCU_DEVICE_ID)
  else $error("device identity wrong");

  a_thread_count:
  assert property (id_read(pir_pkg::ID_THREADS)
    |=> rsp_data == {24'h000000, $past(max_thread_count)})
  else $error("thread count wrong");

  a_microcode_rev:
  assert property (id_read(pir_pkg::ID_MICROCODE) |=> rsp_data == $past(microcode_rev))
  else $error("microcode revision wrong");

  a_mc_sticky:
  assert property (machine_check_error_flag ##[1:2] id_read(pir_pkg::ID_MACHINE_CHECK)
    |=> rsp_data[29] && rsp_data[28:0] == $past(error_source_log))
  else $error("machine check bit lost");

  a_unit_defaults:
  assert property (svc_read(pir_pkg::SVC_SKU_UNIT)
    |=> rsp_ok && rsp_data[3:0] == 4'h3 && rsp_data[12:8] == 5'h10 && rsp_data[19:16] == 4'hA)
  else $error("unit word wrong");

  a_sku_halves:
  assert property (svc_read(pir_pkg::SVC_SKU_HI) |=> rsp_data == $past(s_reg.sku[63:32]))
  else $error("sku upper half wrong");

  a_sku_frozen:
  assert property (s_reg.sku_loaded |=> $stable(s_reg.sku) && s_reg.sku[63:55] == 9'h000
    && !s_reg.sku[47] && !s_reg.sku[31] && !s_reg.sku[15])
  else $error("sku data changed or reserved set");

  c_table_read: cover property (s_reg.phase == pir_pkg::PH_DATA ##1 rsp_valid);
  c_mc_read: cover property (id_read(pir_pkg::ID_MACHINE_CHECK) && s_reg.cat_err);
  c_sku_lo: cover property (svc_read(pir_pkg::SVC_SKU_LO) ##1 rsp_valid);
  c_refused: cover property (rsp_valid && !rsp_ok);

endmodule

// ---- src/pir_pkg.sv ----
// Purpose: Shared constants and word layouts for the package config read services
// Assumes: One clock, synchronous active-high reset
// Notes: Service and parameter codes not fixed elsewhere are plain defaults here
package pir_pkg;

  // ==========================================================
  // Service indices and parameter codes
  localparam logic [7:0] SVC_PKG_ID = 8'h00;
  localparam logic [7:0] SVC_SKU_UNIT = 8'h1E;
  localparam logic [7:0] SVC_SKU_LO = 8'h1C;
  localparam logic [7:0] SVC_SKU_HI = 8'h1D;
  localparam logic [7:0] SVC_REQ_TABLE = 8'h27;
  localparam logic [15:0] ID_SIGNATURE = 16'h0000;
  localparam logic [15:0] ID_PLATFORM = 16'h0001;
  localparam logic [15:0] ID_DEVICE = 16'h0002;
  localparam logic [15:0] ID_THREADS = 16'h0003;
  localparam logic [15:0] ID_MICROCODE = 16'h0004;
  localparam logic [15:0] ID_MACHINE_CHECK = 16'h0005;

  // ==========================================================
  // Fixed values
  // Arbitrary neutral identity value
  localparam logic [31:0] PCU_DEVICE_ID = 32'h0000_0ABC;
  localparam logic [3:0] UNIT_POWER_DEF = 4'h3;
  localparam logic [4:0] UNIT_ENERGY_DEF = 5'h10;
  localparam logic [3:0] UNIT_TIME_DEF = 4'hA;
  localparam logic [1:0] STRIKE_LIMIT = 2'h3;

  // ==========================================================
  // Word layouts, most significant field first
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [7:0] ext_family;
    logic [3:0] ext_model;
    logic [1:0] rsvd_mid;
    logic [1:0] proc_type;
    logic [3:0] family;
    logic [3:0] model;
    logic [3:0] stepping;
  } pir_sig_word_type;

  typedef struct packed {
    logic cat_err;
    logic int_err;
    logic mc_err;
    logic [28:0] source_log;
  } pir_mc_word_type;

  typedef struct packed {
    logic [11:0] rsvd_hi;
    logic [3:0] time_unit;
    logic [2:0] rsvd_mid;
    logic [4:0] energy_unit;
    logic [3:0] rsvd_lo;
    logic [3:0] power_unit;
  } pir_unit_word_type;

  localparam pir_unit_word_type UNIT_WORD = '{rsvd_hi: 12'h000, time_unit: UNIT_TIME_DEF,
    rsvd_mid: 3'h0, energy_unit: UNIT_ENERGY_DEF, rsvd_lo: 4'h0, power_unit: UNIT_POWER_DEF};

  typedef struct packed {
    logic [8:0] rsvd_63;
    logic [6:0] max_window;
    logic rsvd_47;
    logic [14:0] max_power;
    logic rsvd_31;
    logic [14:0] min_power;
    logic rsvd_15;
    logic [14:0] design_thermal_power;
  } pir_sku_word_type;

  typedef struct packed {
    logic read_mode;
    logic [4:0] rsvd;
    logic [1:0] bank;
    logic [3:0] entry;
    logic [3:0] slice;
  } pir_tbl_param_type;

  typedef struct packed {
    logic [26:0] rsvd;
    logic valid;
    logic [3:0] core_id;
  } pir_core_word_type;

  // ==========================================================
  // Block state
  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} pir_phase_type;

  typedef struct packed {
    pir_phase_type phase;
    logic rsp_valid;
    logic rsp_ok;
    logic [31:0] rsp_data;
    logic tbl_en;
    logic [3:0] tbl_slice;
    logic [3:0] tbl_entry;
    logic [1:0] tbl_bank;
    logic [1:0] strikes;
    logic mc_err;
    logic int_err;
    logic cat_err;
    logic sku_loaded;
    pir_sku_word_type sku;
  } pir_state_type;

  localparam pir_state_type STATE_RST = '{phase: PH_IDLE, rsp_valid: 1'b0, rsp_ok: 1'b0,
    rsp_data: 32'h0000_0000, tbl_en: 1'b0, tbl_slice: 4'h0, tbl_entry: 4'h0, tbl_bank: 2'h0,
    strikes: 2'h0, mc_err: 1'b0, int_err: 1'b0, cat_err: 1'b0, sku_loaded: 1'b0,
    sku: 64'h0000_0000_0000_0000};

endpackage

// ---- test/pir_table_model.sv ----
// Purpose: Request table read port model for the config read block
// Assumes: Read data is wanted in the cycle after table_rd_en
// Notes: Outside that cycle the data toggles so a sample one cycle late never matches
`timescale 1ns/100ps

module pir_table_model (
  input wire logic clk,
  input wire logic table_rd_en,
  input wire logic [3:0] table_rd_slice,
  input wire logic [3:0] table_rd_entry,
  input wire logic [1:0] table_rd_bank,
  output logic [31:0] table_rd_data
);
  // ==========================================================
  // Entry contents
  // Contents follow the address, so a wrong slot or bank shows up in the answer
  initial table_rd_data = 32'h5A5A_5A5A;

  always @(posedge clk)
  begin
    if (table_rd_en === 1'b1)
      table_rd_data <= {8'hA5, 14'h0000, table_rd_bank, table_rd_entry, table_rd_slice};
    else
      table_rd_data <= ~table_rd_data;
  end
endmodule

// ---- test/pir_config_reads_bench.sv ----
// Purpose: Self-checking bench for the package config read services
// Assumes: Inputs change on the falling clock edge
// Notes: Expected words are built by hand from the word field layouts
`timescale 1ns/100ps

module pir_config_reads_bench;
  logic clk;
  logic rst;
  logic req_valid;
  logic [7:0] req_index;
  logic [15:0] req_param;
  logic rsp_valid;
  logic rsp_ok;
  logic [31:0] rsp_data;
  pir_pkg::pir_sig_word_type sig;
  pir_pkg::pir_sku_word_type sku;
  logic [15:0] core_mask;
  logic core_valid;
  logic [3:0] evt;
  logic table_rd_en;
  logic [3:0] rd_slice;
  logic [3:0] rd_entry;
  logic [1:0] rd_bank;
  logic [31:0] rd_data;
  logic [31:0] mc_exp;
  logic [31:0] rd_addr;
  int rd_count;
  int err_total;
  int num_checks;
  int cycles;

  pir_config_reads pir_config_reads_i (
    .clk(clk),
    .rst(rst),
    .req_valid(req_valid),
    .req_index(req_index),
    .req_param(req_param),
    .rsp_valid(rsp_valid),
    .rsp_ok(rsp_ok),
    .rsp_data(rsp_data),
    .signature(sig),
    .platform_flags(3'h5),
    .max_thread_count(8'h18),
    .microcode_rev(32'hC0DE_1234),
    .machine_check_error_flag(evt[0]),
    .internal_error_flag(evt[1]),
    .catastrophic_error_signal_n(~evt[3]),
    .error_source_log(29'h01AB_CDEF),
    .sku_default(sku),
    .core_enable_mask(core_mask),
    .timeout_strike(evt[2]),
    .timeout_core_id(4'h9),
    .timeout_core_valid(core_valid),
    .table_rd_en(table_rd_en),
    .table_rd_slice(rd_slice),
    .table_rd_entry(rd_entry),
    .table_rd_bank(rd_bank),
    .table_rd_data(rd_data)
  );

  pir_table_model pir_table_model_i (
    .clk(clk),
    .table_rd_en(table_rd_en),
    .table_rd_slice(rd_slice),
    .table_rd_entry(rd_entry),
    .table_rd_bank(rd_bank),
    .table_rd_data(rd_data)
  );

  // ==========================================================
  // Clock, watchdog and table port monitor
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (table_rd_en === 1'b1)
    begin
      rd_count++;
      rd_addr <= {22'h0, rd_slice, rd_entry, rd_bank};
    end
    if (cycles == 2000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Checking and request tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Latency counted in cycles from the falling edge that raises the strobe to the falling edge that sees the answer marker
  task automatic req(input logic [7:0] idx, input logic [15:0] prm, input logic ok,
                     input logic [31:0] dat, input int lat);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_index = idx;
    req_param = prm;
    n = 0;
    // The answer marker stands one cycle, so look at the negedge that drops the strobe too
    do
    begin
      @(negedge clk);
      req_valid = 1'b0;
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 8);
    check({31'h0, rsp_ok}, {31'h0, ok});
    check(rsp_data, dat);
    check(32'(n), 32'(lat));
    @(negedge clk);
    check({31'h0, rsp_valid}, 32'h0000_0000);
  endtask

  task automatic pulse(input logic [3:0] m);
    @(negedge clk);
    evt = m;
    @(negedge clk);
    evt = 4'h0;
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_index = 8'h00;
    req_param = 16'h0000;
    sig = 32'hF765_E321;
    sku = 64'hFF9A_D234_F5A5_9876;
    core_mask = 16'hFFFF;
    core_valid = 1'b1;
    evt = 4'h0;
    rd_count = 0;
    rd_addr = 32'h0000_0000;
    err_total = 0;
    num_checks = 0;
    cycles = 0;
    repeat (6) @(negedge clk);
    check({31'h0, rsp_valid}, 32'h0000_0000);
    check(rsp_data, 32'h0000_0000);
    rst = 1'b0;
    req(8'h00, 16'h0000, 1'b1, 32'h0765_2321, 1);
    req(8'h00, 16'h0001, 1'b1, 32'h0000_0005, 1);
    req(8'h00, 16'h0002, 1'b1, pir_pkg::PCU_DEVICE_ID, 1);
    core_mask = 16'hFFFB;
    req(8'h00, 16'h0003, 1'b1, 32'h0000_0018, 1);
    req(8'h00, 16'h0004, 1'b1, 32'hC0DE_1234, 1);
    mc_exp = 32'h01AB_CDEF;
    req(8'h00, 16'h0005, 1'b1, mc_exp, 1);
    // Flags stay sticky, so each read must also keep the earlier bits
    for (int i = 0; i < 3; i++)
    begin
      pulse(i == 2 ? 4'h8 : 4'h1 << i);
      mc_exp = mc_exp | (32'h2000_0000 << i);
      req(8'h00, 16'h0005, 1'b1, mc_exp, 1);
    end
    req(8'h00, 16'h0006, 1'b0, 32'h0000_0000, 1);
    // Minimum window comes from a local config read elsewhere, never from this block
    req(8'h55, 16'h0000, 1'b0, 32'h0000_0000, 1);
    req(8'h1E, 16'h0000, 1'b1, {12'h0, 4'hA, 3'h0, 5'h10, 4'h0, 4'h3}, 1);
    req(8'h1D, 16'h0000, 1'b1, 32'h001A_5234, 1);
    req(8'h1C, 16'h0000, 1'b1, 32'h75A5_1876, 1);
    sku = 64'h0000_0000_0000_0000;
    req(8'h1C, 16'h0000, 1'b1, 32'h75A5_1876, 1);
    req(8'h27, 16'h0172, 1'b0, 32'h0000_0000, 1);
    check(32'(rd_count), 32'h0000_0000);
    repeat (4) pulse(4'h4);
    req(8'h27, 16'h0172, 1'b0, 32'h0000_0000, 1);
    core_mask = 16'hFFFF;
    req(8'h27, 16'h0172, 1'b1, 32'hA500_0172, 3);
    check(32'(rd_count), 32'h0000_0001);
    check(rd_addr, {22'h0, 4'h2, 4'h7, 2'h1});
    req(8'h27, 16'h8000, 1'b1, 32'h0000_0019, 1);
    core_valid = 1'b0;
    req(8'h27, 16'h8000, 1'b1, 32'h0000_0009, 1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    req(8'h00, 16'h0005, 1'b1, 32'h01AB_CDEF, 1);
    req(8'h27, 16'h0172, 1'b0, 32'h0000_0000, 1);
    check(32'(rd_count), 32'h0000_0001);
    tally_and_finish();
  end
endmodule
